/* rtl/ldio_bank.sv */
/*
  logical device configuration bank and host io address decode.
  assumes the host interface logic delivers index/data port strobes and io
  cycle addresses on core_clk, so none of them is synchronised here.
*/
// Overview of operation
// - dma choice byte 0x74 exists only for floppy and parallel devices.
// - index 0x75 ignores writes and reads zero in every bank.
// - indices 0x76-0xA8 and 0xA9-0xDF ignore writes, read zero.
// - 0xE0-0xFE hold vendor per-device registers; 0xFF is reserved.
// - a device is on when its activation or power bit is set.
// - activation and power bits are coupled; changing one changes both.
// - base outside the device's permitted range means no decode.
// - reset loads primary interrupt of device 0 with 0x06.
// - reset loads dma choice 0x02 for device 0, 0x04 for 3 and 5.
// - floppy decodes 8 bytes, base 0x100-0xFF8 aligned 8, offset 6 unused.
// - parallel base 0x100-0xFFC aligned 4; offsets 3-7 only if 8-aligned.
// - parallel also decodes base plus 400h, 401h and 402h.
// - serial ports decode 8 bytes, base 0x100-0xFF8 aligned 8.
// - keyboard ignores base registers, decodes fixed 60h and 64h.
// - game port decodes one byte, base anywhere 0x100-0xFFF.
// - global index 0x07 selects the bank seen at 0x30 and above.
// - base address is index 0x60 high byte, 0x61 low byte.
// - bit 0 of index 0x30 activates or deactivates the selected device.
`include "ldio_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ldio_bank (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic cfg_mode,
   input wire logic cfg_idx_wr,
   input wire logic cfg_dat_wr,
   input wire logic cfg_dat_rd,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   input wire logic pwr_wr,
   input wire logic [3:0] pwr_dev,
   input wire logic pwr_val,
   input wire logic io_cyc,
   input wire logic [15:0] io_addr,
   output logic [9:0] io_sel,
   output logic [9:0] dev_on,
   output logic [39:0] irq_sel,
   output logic [29:0] dma_sel
);
   ldio_pkg::ldio_bank_s s_r;
   ldio_pkg::ldio_bank_s s_nxt;
   ldio_vmem_if vm ();

   function automatic logic dev_valid(input ldio_pkg::ldio_dev_t d);
      dev_valid = (d == `LDIO_DEV_FLOPPY) || (d == `LDIO_DEV_PARALLEL) ||
                  (d == `LDIO_DEV_SERIAL1) || (d == `LDIO_DEV_SERIAL2) ||
                  (d == `LDIO_DEV_KEYBOARD) || (d == `LDIO_DEV_GAME);
   endfunction

   function automatic logic has_dma(input ldio_pkg::ldio_dev_t d);
      has_dma = (d == `LDIO_DEV_FLOPPY) || (d == `LDIO_DEV_PARALLEL);
   endfunction

   function automatic logic has_base(input ldio_pkg::ldio_dev_t d);
      has_base = dev_valid(d) && (d != `LDIO_DEV_KEYBOARD);
   endfunction

   function automatic logic [2:0] slot(input ldio_pkg::ldio_dev_t d);
      case (d)
         `LDIO_DEV_FLOPPY: slot = 3'd0;
         `LDIO_DEV_PARALLEL: slot = 3'd1;
         `LDIO_DEV_SERIAL1: slot = 3'd2;
         `LDIO_DEV_SERIAL2: slot = 3'd3;
         `LDIO_DEV_KEYBOARD: slot = 3'd4;
         default: slot = 3'd5;
      endcase
   endfunction

   // base legal when inside [lo:hi] and on the required alignment
   function automatic logic base_ok(input logic [15:0] b, input logic [15:0] hi,
                                    input logic [15:0] mask);
      base_ok = (b >= `LDIO_BASE_MIN) && (b <= hi) && ((b & mask) == 16'h0000);
   endfunction

   function automatic logic [15:0] base_of(input ldio_pkg::ldio_bank_s s, input int d);
      base_of = {s.base_hi[d], s.base_lo[d]};
   endfunction

   logic [9:0] hit;
   logic [15:0] b_fdc, b_par, b_s1, b_s2, b_game, par_ofs;
   logic par_epp;

   // window decode; qualified by activation below, so a disabled device stays silent
   always_comb begin
      b_fdc = base_of(s_r, 0);
      b_par = base_of(s_r, 3);
      b_s1 = base_of(s_r, 4);
      b_s2 = base_of(s_r, 5);
      b_game = base_of(s_r, 9);
      par_ofs = io_addr - b_par;
      par_epp = base_ok(b_par, `LDIO_BASE_MAX8, `LDIO_ALIGN8);
      hit = '0;
      hit[0] = base_ok(b_fdc, `LDIO_BASE_MAX8, `LDIO_ALIGN8) &&
               (io_addr[15:3] == b_fdc[15:3]) &&
               ((io_addr - b_fdc) != `LDIO_FLOPPY_HOLE);
      hit[3] = base_ok(b_par, `LDIO_BASE_MAX4, `LDIO_ALIGN4) &&
               ((io_addr >= b_par && par_ofs <= `LDIO_PAR_STD_LAST) ||
                (par_epp && io_addr >= b_par && par_ofs <= `LDIO_PAR_EPP_LAST) ||
                (par_ofs >= `LDIO_PAR_ECP_LO && par_ofs <= `LDIO_PAR_ECP_HI));
      hit[4] = base_ok(b_s1, `LDIO_BASE_MAX8, `LDIO_ALIGN8) &&
               (io_addr[15:3] == b_s1[15:3]);
      hit[5] = base_ok(b_s2, `LDIO_BASE_MAX8, `LDIO_ALIGN8) &&
               (io_addr[15:3] == b_s2[15:3]);
      hit[7] = (io_addr == `LDIO_KBD_DATA) || (io_addr == `LDIO_KBD_CMD);
      hit[9] = base_ok(b_game, `LDIO_BASE_MAX1, `LDIO_ALIGN1) && (io_addr == b_game);
   end

   logic in_bank, is_vend;

   always_comb begin
      s_nxt = s_r;
      in_bank = (s_r.idx >= `LDIO_IDX_BANK_LO) && dev_valid(s_r.ldn);
      is_vend = (s_r.idx >= `LDIO_IDX_VEND_LO) && (s_r.idx <= `LDIO_IDX_VEND_HI);
      vm.we = 1'b0;
      vm.addr = {slot(s_r.ldn), s_r.idx[4:0]};
      vm.wdata = cfg_wdata;
      if (cfg_mode && cfg_idx_wr) begin
         s_nxt.idx = cfg_wdata;
      end
      if (cfg_mode && cfg_dat_wr) begin
         if (s_r.idx == `LDIO_IDX_LDN) begin
            s_nxt.ldn = cfg_wdata[3:0];
         end else if (in_bank) begin
            // unlisted indices outside vendor 0xE0-0xFE, such as 0x75, 0x76-0xDF and 0xFF, drop the write
            case (s_r.idx)
               `LDIO_IDX_ACT: s_nxt.act[s_r.ldn] = cfg_wdata[0];
               `LDIO_IDX_BASE_HI: begin
                  if (has_base(s_r.ldn)) begin
                     s_nxt.base_hi[s_r.ldn] = cfg_wdata;
                  end
               end
               `LDIO_IDX_BASE_LO: begin
                  if (has_base(s_r.ldn)) begin
                     s_nxt.base_lo[s_r.ldn] = cfg_wdata;
                  end
               end
               `LDIO_IDX_IRQ: s_nxt.irq[s_r.ldn] = cfg_wdata[3:0];
               `LDIO_IDX_DMA: begin
                  if (has_dma(s_r.ldn)) begin
                     s_nxt.dma[s_r.ldn] = cfg_wdata[2:0];
                  end
               end
               default: vm.we = is_vend;
            endcase
         end
      end
      // power/control side shares the one stored bit, so both views always agree
      if (pwr_wr && dev_valid(pwr_dev)) begin
         s_nxt.act[pwr_dev] = pwr_val;
      end
      s_nxt.rdata = s_r.rdata;
      if (cfg_dat_rd) begin
         s_nxt.rdata = 8'h00;
         if (!cfg_mode) begin
            s_nxt.rdata = 8'h00;
         end else if (s_r.idx == `LDIO_IDX_LDN) begin
            s_nxt.rdata = {4'h0, s_r.ldn};
         end else if (in_bank) begin
            case (s_r.idx)
               `LDIO_IDX_ACT: s_nxt.rdata = {7'h00, s_r.act[s_r.ldn]};
               `LDIO_IDX_BASE_HI: s_nxt.rdata = has_base(s_r.ldn) ? s_r.base_hi[s_r.ldn] : 8'h00;
               `LDIO_IDX_BASE_LO: s_nxt.rdata = has_base(s_r.ldn) ? s_r.base_lo[s_r.ldn] : 8'h00;
               `LDIO_IDX_IRQ: s_nxt.rdata = {4'h0, s_r.irq[s_r.ldn]};
               `LDIO_IDX_DMA: s_nxt.rdata = has_dma(s_r.ldn) ? {5'h00, s_r.dma[s_r.ldn]} : 8'h00;
               default: s_nxt.rdata = is_vend ? vm.rdata : 8'h00;
            endcase
         end
      end
      s_nxt.sel = io_cyc ? (hit & s_r.act) : '0;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_r <= '0;
         s_r.irq[0] <= `LDIO_IRQ_RST_FLOPPY;
         s_r.dma[0] <= `LDIO_DMA_RST_FLOPPY;
         s_r.dma[3] <= `LDIO_DMA_RST_PAR_SER;
         s_r.dma[5] <= `LDIO_DMA_RST_PAR_SER;
      end else begin
         s_r <= s_nxt;
      end
   end

   ldio_vmem u_vmem (
      .core_clk(core_clk),
      .nrst(nrst),
      .port(vm.mem)
   );

   assign cfg_rdata = s_r.rdata;
   assign io_sel = s_r.sel;
   assign dev_on = s_r.act;
   assign irq_sel = s_r.irq;
   assign dma_sel = s_r.dma;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence bank_rd_s(logic [7:0] i);
      cfg_mode && cfg_dat_rd && s_r.idx == i;
   endsequence

   ldn_select_a: assert property (cfg_mode && cfg_dat_wr && s_r.idx == `LDIO_IDX_LDN && !cfg_idx_wr
      |=> s_r.ldn == $past(cfg_wdata[3:0])) else $error("bank select not taken");
   spare_zero_a: assert property (bank_rd_s(`LDIO_IDX_DMA_SPARE) |=> cfg_rdata == 8'h00)
      else $error("index 0x75 read nonzero");
   rsvd_zero_a: assert property (cfg_dat_rd && s_r.idx >= `LDIO_IDX_RSVA_LO &&
      s_r.idx <= `LDIO_IDX_RSVB_HI |=> cfg_rdata == 8'h00) else $error("reserved read nonzero");
   last_zero_a: assert property (bank_rd_s(`LDIO_IDX_LAST) |=> cfg_rdata == 8'h00)
      else $error("index 0xFF read nonzero");
   dma_hidden_a: assert property (bank_rd_s(`LDIO_IDX_DMA) && !has_dma(s_r.ldn)
      |=> cfg_rdata == 8'h00) else $error("dma byte seen on other device");
   power_link_a: assert property (pwr_wr && dev_valid(pwr_dev) && !(cfg_mode && cfg_dat_wr)
      |=> dev_on[$past(pwr_dev)] == $past(pwr_val)) else $error("power bit not linked");
   sel_active_a: assert property ((io_sel & ~$past(dev_on)) == 10'h000)
      else $error("decode of inactive device");
   kbd_fixed_a: assert property (io_cyc && dev_on[7] && io_addr == `LDIO_KBD_CMD
      |=> io_sel[7]) else $error("keyboard port missed");
   fdc_hole_a: assert property (io_cyc && io_addr == b_fdc + `LDIO_FLOPPY_HOLE
      |=> !io_sel[0]) else $error("floppy offset 6 decoded");
   serial_range_a: assert property (io_sel[4] |-> $past(b_s1) >= `LDIO_BASE_MIN &&
      $past(b_s1) <= `LDIO_BASE_MAX8) else $error("serial decode with bad base");
   reset_vals_a: assert property ($rose(nrst) |-> irq_sel[3:0] == `LDIO_IRQ_RST_FLOPPY &&
      dma_sel[2:0] == `LDIO_DMA_RST_FLOPPY && dma_sel[11:9] == `LDIO_DMA_RST_PAR_SER &&
      dma_sel[17:15] == `LDIO_DMA_RST_PAR_SER) else $error("reset defaults wrong");

   // write steps into a bank of a device that exists
   sequence bank_wr_s(logic [7:0] i);
      cfg_mode && cfg_dat_wr && s_r.idx == i && dev_valid(s_r.ldn);
   endsequence

   idx_take_a: assert property (cfg_mode && cfg_idx_wr |=> s_r.idx == $past(cfg_wdata))
      else $error("index not taken");
   mode_gate_a: assert property (!cfg_mode && cfg_dat_rd |=> cfg_rdata == 8'h00)
      else $error("read outside configuration state");
   base_hi_wr_a: assert property (bank_wr_s(`LDIO_IDX_BASE_HI) && has_base(s_r.ldn)
      |=> s_r.base_hi[$past(s_r.ldn)] == $past(cfg_wdata)) else $error("base high lost");
   base_lo_wr_a: assert property (bank_wr_s(`LDIO_IDX_BASE_LO) && has_base(s_r.ldn)
      |=> s_r.base_lo[$past(s_r.ldn)] == $past(cfg_wdata)) else $error("base low lost");
   dma_keep_a: assert property (bank_wr_s(`LDIO_IDX_DMA) && !has_dma(s_r.ldn)
      |=> $stable(dma_sel)) else $error("dma byte written on other device");
   act_wr_a: assert property (bank_wr_s(`LDIO_IDX_ACT) && !(pwr_wr && pwr_dev == s_r.ldn)
      |=> dev_on[$past(s_r.ldn)] == $past(cfg_wdata[0])) else $error("activate lost");
   rsvd_off_a: assert property ((dev_on & 10'h146) == 10'h000)
      else $error("reserved device on");
   rsvd_sel_a: assert property ((io_sel & 10'h146) == 10'h000)
      else $error("reserved device decoded");
   kbd_data_a: assert property (io_cyc && dev_on[7] && io_addr == `LDIO_KBD_DATA
      |=> io_sel[7]) else $error("keyboard data port missed");
   game_exact_a: assert property (io_sel[9] |-> $past(io_addr) == $past(b_game))
      else $error("game port decode off base");
   par_epp_gate_a: assert property (io_cyc && !par_epp && par_ofs > `LDIO_PAR_STD_LAST &&
      par_ofs <= `LDIO_PAR_EPP_LAST |=> !io_sel[3]) else $error("epp offset decoded");
   par_ecp_a: assert property (io_cyc && dev_on[3] && base_ok(b_par, `LDIO_BASE_MAX4,
      `LDIO_ALIGN4) && par_ofs >= `LDIO_PAR_ECP_LO && par_ofs <= `LDIO_PAR_ECP_HI
      |=> io_sel[3]) else $error("ecp window missed");
   sel_pulse_a: assert property (!io_cyc |=> io_sel == 10'h000)
      else $error("decode without io cycle");
   fdc_range_a: assert property (io_sel[0] |-> $past(b_fdc) >= `LDIO_BASE_MIN &&
      $past(b_fdc) <= `LDIO_BASE_MAX8) else $error("floppy decode with bad base");
endmodule // ldio_bank

`default_nettype wire

/* rtl/ldio_consts.svh */
/*
  constants of the logical device register bank and io decode: bank indices,
  reset values, device numbers and base address ranges.
  assumes inclusion by ldio_pkg and the design modules; definitions only.
*/
`ifndef LDIO_CONSTS_SVH
`define LDIO_CONSTS_SVH

`define LDIO_IDX_LDN 8'h07
`define LDIO_IDX_BANK_LO 8'h30
`define LDIO_IDX_ACT 8'h30
`define LDIO_IDX_BASE_HI 8'h60
`define LDIO_IDX_BASE_LO 8'h61
`define LDIO_IDX_IRQ 8'h70
`define LDIO_IDX_DMA 8'h74
`define LDIO_IDX_DMA_SPARE 8'h75
`define LDIO_IDX_RSVA_LO 8'h76
`define LDIO_IDX_RSVA_HI 8'hA8
`define LDIO_IDX_RSVB_LO 8'hA9
`define LDIO_IDX_RSVB_HI 8'hDF
`define LDIO_IDX_VEND_LO 8'hE0
`define LDIO_IDX_VEND_HI 8'hFE
`define LDIO_IDX_LAST 8'hFF

`define LDIO_DEV_FLOPPY 4'h0
`define LDIO_DEV_PARALLEL 4'h3
`define LDIO_DEV_SERIAL1 4'h4
`define LDIO_DEV_SERIAL2 4'h5
`define LDIO_DEV_KEYBOARD 4'h7
`define LDIO_DEV_GAME 4'h9
`define LDIO_NDEV 10
`define LDIO_NSLOT 6
`define LDIO_MEM_DEPTH 192

`define LDIO_IRQ_RST 4'h0
`define LDIO_IRQ_RST_FLOPPY 4'h6
`define LDIO_DMA_RST 3'h0
`define LDIO_DMA_RST_FLOPPY 3'h2
`define LDIO_DMA_RST_PAR_SER 3'h4

`define LDIO_BASE_MIN 16'h0100
`define LDIO_BASE_MAX8 16'h0FF8
`define LDIO_BASE_MAX4 16'h0FFC
`define LDIO_BASE_MAX1 16'h0FFF
`define LDIO_ALIGN8 16'h0007
`define LDIO_ALIGN4 16'h0003
`define LDIO_ALIGN1 16'h0000
`define LDIO_FLOPPY_HOLE 16'h0006
`define LDIO_PAR_STD_LAST 16'h0002
`define LDIO_PAR_EPP_LAST 16'h0007
`define LDIO_PAR_ECP_LO 16'h0400
`define LDIO_PAR_ECP_HI 16'h0402
`define LDIO_KBD_DATA 16'h0060
`define LDIO_KBD_CMD 16'h0064

`endif

/* rtl/ldio_pkg.sv */
/*
  types shared by the logical device bank modules.
  assumes ldio_consts.svh is on the include path.
*/
`include "ldio_consts.svh"

package ldio_pkg;
   typedef logic [7:0] ldio_byte_t;
   typedef logic [3:0] ldio_dev_t;

   typedef struct packed {
      ldio_dev_t ldn;
      ldio_byte_t idx;
      logic [`LDIO_NDEV-1:0] act;
      logic [`LDIO_NDEV-1:0][7:0] base_hi;
      logic [`LDIO_NDEV-1:0][7:0] base_lo;
      logic [`LDIO_NDEV-1:0][3:0] irq;
      logic [`LDIO_NDEV-1:0][2:0] dma;
      ldio_byte_t rdata;
      logic [`LDIO_NDEV-1:0] sel;
   } ldio_bank_s;

   typedef struct packed {
      logic [`LDIO_MEM_DEPTH-1:0][7:0] mem;
      ldio_byte_t rdata;
   } ldio_vmem_s;
endpackage

/* rtl/ldio_vmem_if.sv */
/*
  carrier between the bank logic and its vendor-register memory.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface ldio_vmem_if;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport bank (output we, output addr, output wdata, input rdata);
   modport mem (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

/* rtl/ldio_vmem.sv */
/*
  per-device storage of the vendor bank registers, six devices of 32 bytes.
  assumes synchronous active-low reset; read data are registered, so a value
  written shows on rdata one edge after the write.
*/
`include "ldio_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ldio_vmem (
   input wire logic core_clk,
   input wire logic nrst,
   ldio_vmem_if.mem port
);
   ldio_pkg::ldio_vmem_s s_r;
   ldio_pkg::ldio_vmem_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (port.we && port.addr < 8'(`LDIO_MEM_DEPTH)) begin
         s_nxt.mem[port.addr] = port.wdata;
      end
      s_nxt.rdata = (port.addr < 8'(`LDIO_MEM_DEPTH)) ? s_r.mem[port.addr] : 8'h00;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign port.rdata = s_r.rdata;
endmodule // ldio_vmem

`default_nettype wire

/* tb/ldio_host.sv */
/*
  host side model: drives the index/data port, power/control writes and io cycles.
  assumes the bank samples every request on the rising edge of core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ldio_host (
   input wire logic core_clk,
   input wire logic [7:0] cfg_rdata,
   input wire logic [9:0] io_sel,
   output logic cfg_mode,
   output logic cfg_idx_wr,
   output logic cfg_dat_wr,
   output logic cfg_dat_rd,
   output logic [7:0] cfg_wdata,
   output logic pwr_wr,
   output logic [3:0] pwr_dev,
   output logic pwr_val,
   output logic io_cyc,
   output logic [15:0] io_addr
);
   initial begin
      cfg_mode = 1'b1;
      cfg_idx_wr = 1'b0;
      cfg_dat_wr = 1'b0;
      cfg_dat_rd = 1'b0;
      cfg_wdata = 8'h00;
      pwr_wr = 1'b0;
      pwr_dev = 4'h0;
      pwr_val = 1'b0;
      io_cyc = 1'b0;
      io_addr = 16'h0000;
   end

   // the index written this way picks the register that the next data access reaches
   task automatic put_idx(input logic [7:0] idx);
      @(posedge core_clk);
      cfg_idx_wr <= 1'b1;
      cfg_wdata <= idx;
      @(posedge core_clk);
      cfg_idx_wr <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      put_idx(idx);
      cfg_dat_wr <= 1'b1;
      cfg_wdata <= data;
      @(posedge core_clk);
      cfg_dat_wr <= 1'b0;
      cfg_wdata <= ~data;
   endtask

   // two idle edges first: vendor bytes come from a registered memory
   task automatic rd(input logic [7:0] idx, output logic [7:0] data);
      put_idx(idx);
      cfg_wdata <= ~idx;
      repeat (2) @(posedge core_clk);
      cfg_dat_rd <= 1'b1;
      @(posedge core_clk);
      cfg_dat_rd <= 1'b0;
      #1 data = cfg_rdata;
   endtask

   // configuration state on or off; writes and reads are refused while off
   task automatic mode(input logic m);
      @(posedge core_clk);
      cfg_mode <= m;
   endtask

   task automatic probe(input logic [15:0] addr, output logic [9:0] sel);
      @(posedge core_clk);
      io_cyc <= 1'b1;
      io_addr <= addr;
      @(posedge core_clk);
      io_cyc <= 1'b0;
      io_addr <= ~addr;
      #1 sel = io_sel;
   endtask

   task automatic pwr(input logic [3:0] dev, input logic val);
      @(posedge core_clk);
      pwr_wr <= 1'b1;
      pwr_dev <= dev;
      pwr_val <= val;
      @(posedge core_clk);
      pwr_wr <= 1'b0;
      pwr_val <= ~val;
      #1;
   endtask
endmodule // ldio_host

`default_nettype wire

/* tb/tb_logical_device_io_decode.sv */
/*
  self-checking bench for the logical device bank and io decode.
  assumes ldio_bank as top with its vendor memory inside; host model drives it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_logical_device_io_decode;
   localparam logic [7:0] RSV [4] = '{8'h76, 8'hA8, 8'hA9, 8'hDF};
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic cfg_mode, cfg_idx_wr, cfg_dat_wr, cfg_dat_rd, pwr_wr, pwr_val, io_cyc;
   logic [7:0] cfg_wdata, cfg_rdata;
   logic [3:0] pwr_dev;
   logic [15:0] io_addr;
   logic [9:0] io_sel, dev_on;
   logic [39:0] irq_sel;
   logic [29:0] dma_sel;
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;

   always #2.5 core_clk = ~core_clk;

   ldio_host u_ldio_host (.core_clk(core_clk), .cfg_rdata(cfg_rdata), .io_sel(io_sel),
      .cfg_mode(cfg_mode), .cfg_idx_wr(cfg_idx_wr), .cfg_dat_wr(cfg_dat_wr),
      .cfg_dat_rd(cfg_dat_rd), .cfg_wdata(cfg_wdata), .pwr_wr(pwr_wr), .pwr_dev(pwr_dev),
      .pwr_val(pwr_val), .io_cyc(io_cyc), .io_addr(io_addr));

   ldio_bank u_ldio_bank (.core_clk(core_clk), .nrst(nrst), .cfg_mode(cfg_mode),
      .cfg_idx_wr(cfg_idx_wr), .cfg_dat_wr(cfg_dat_wr), .cfg_dat_rd(cfg_dat_rd),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pwr_wr(pwr_wr), .pwr_dev(pwr_dev),
      .pwr_val(pwr_val), .io_cyc(io_cyc), .io_addr(io_addr), .io_sel(io_sel),
      .dev_on(dev_on), .irq_sel(irq_sel), .dma_sel(dma_sel));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         end_sim();
      end
   end

   task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic chk_v(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      u_ldio_host.rd(idx, d);
      chk_b(d, exp);
   endtask

   task automatic pc(input logic [15:0] addr, input logic [9:0] exp);
      logic [9:0] s;
      u_ldio_host.probe(addr, s);
      chk_v({30'h0, s}, {30'h0, exp});
   endtask

   task automatic set_dev(input logic [7:0] dev, input logic [15:0] base, input logic act);
      u_ldio_host.wr(8'h07, dev);
      u_ldio_host.wr(8'h60, base[15:8]);
      u_ldio_host.wr(8'h61, base[7:0]);
      u_ldio_host.wr(8'h30, {7'h00, act});
   endtask

   task automatic t_reset();
      chk_v({30'h0, dev_on}, 40'h0);
      chk_v(irq_sel, 40'h6);
      chk_v({10'h0, dma_sel}, 40'h20802);
      u_ldio_host.wr(8'h07, 8'h00);
      rdc(8'h70, 8'h06);
      rdc(8'h74, 8'h02);
      u_ldio_host.wr(8'h07, 8'h03);
      rdc(8'h74, 8'h04);
      u_ldio_host.wr(8'h07, 8'h05);
      rdc(8'h74, 8'h00);
   endtask

   task automatic t_bank();
      u_ldio_host.wr(8'h07, 8'h00);
      u_ldio_host.wr(8'h74, 8'hFB);
      rdc(8'h74, 8'h03);
      u_ldio_host.wr(8'h07, 8'h04);
      u_ldio_host.wr(8'h74, 8'h03);
      rdc(8'h74, 8'h00);
      rdc(8'h07, 8'h04);
      u_ldio_host.wr(8'h75, 8'hFF);
      rdc(8'h75, 8'h00);
      for (int i = 0; i < 4; i++) begin
         u_ldio_host.wr(RSV[i], 8'hA5);
         rdc(RSV[i], 8'h00);
      end
      u_ldio_host.wr(8'hE0, 8'h5A);
      u_ldio_host.wr(8'hFE, 8'hC3);
      u_ldio_host.wr(8'hFF, 8'h77);
      rdc(8'hE0, 8'h5A);
      rdc(8'hFE, 8'hC3);
      rdc(8'hFF, 8'h00);
      u_ldio_host.wr(8'h07, 8'h02);
      u_ldio_host.wr(8'h30, 8'h01);
      u_ldio_host.wr(8'h70, 8'h05);
      rdc(8'h30, 8'h00);
      rdc(8'h70, 8'h00);
      chk_v({30'h0, dev_on}, 40'h0);
      u_ldio_host.mode(1'b0);
      u_ldio_host.wr(8'h07, 8'h09);
      rdc(8'h07, 8'h00);
      u_ldio_host.mode(1'b1);
      rdc(8'h07, 8'h02);
   endtask

   task automatic t_power();
      u_ldio_host.pwr(4'h4, 1'b1);
      chk_v({30'h0, dev_on}, 40'h10);
      u_ldio_host.wr(8'h07, 8'h04);
      rdc(8'h30, 8'h01);
      u_ldio_host.wr(8'h30, 8'h00);
      #1 chk_v({30'h0, dev_on}, 40'h0);
      u_ldio_host.wr(8'h30, 8'h01);
      u_ldio_host.pwr(4'h4, 1'b0);
      rdc(8'h30, 8'h00);
   endtask

   task automatic t_decode();
      set_dev(8'h04, 16'h03F8, 1'b1);
      pc(16'h03F8, 10'h010);
      pc(16'h03FF, 10'h010);
      pc(16'h0400, 10'h000);
      set_dev(8'h04, 16'h03F8, 1'b0);
      pc(16'h03F8, 10'h000);
      set_dev(8'h00, 16'h03F0, 1'b1);
      pc(16'h03F5, 10'h001);
      pc(16'h03F6, 10'h000);
      pc(16'h03F7, 10'h001);
      set_dev(8'h00, 16'h0FFC, 1'b1);
      pc(16'h0FFC, 10'h000);
      set_dev(8'h00, 16'h00F8, 1'b1);
      pc(16'h00F8, 10'h000);
      set_dev(8'h00, 16'h00F8, 1'b0);
      set_dev(8'h03, 16'h037C, 1'b1);
      pc(16'h037E, 10'h008);
      pc(16'h037F, 10'h000);
      pc(16'h077C, 10'h008);
      pc(16'h077E, 10'h008);
      pc(16'h077F, 10'h000);
      set_dev(8'h03, 16'h0378, 1'b1);
      pc(16'h037F, 10'h008);
      set_dev(8'h03, 16'h0FFC, 1'b1);
      pc(16'h0FFC, 10'h008);
      set_dev(8'h03, 16'h0FFC, 1'b0);
      set_dev(8'h07, 16'h0300, 1'b1);
      pc(16'h0060, 10'h080);
      pc(16'h0064, 10'h080);
      pc(16'h0300, 10'h000);
      set_dev(8'h09, 16'h0FFF, 1'b1);
      pc(16'h0FFF, 10'h200);
      pc(16'h0FFE, 10'h000);
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      t_reset();
      t_bank();
      t_power();
      t_decode();
      end_sim();
   end
endmodule // tb_logical_device_io_decode

`default_nettype wire
